/* File: rtl/rst_seq_cfg.svh */
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

`define RST_CLK_PERIOD_NS   50
`define RST_TPOR_NS         30000
`define RST_TPOR_CYC        (`RST_TPOR_NS / `RST_CLK_PERIOD_NS)
`define RST_TBOR_NS         100000
`define RST_TBOR_CYC        (`RST_TBOR_NS / `RST_CLK_PERIOD_NS)
`define RST_TOSCD_FRC_NS    1100
`define RST_TOSCD_FRC_CYC   (`RST_TOSCD_FRC_NS / `RST_CLK_PERIOD_NS)
`define RST_TOSCD_LPRC_NS   70000
`define RST_TOSCD_LPRC_CYC  (`RST_TOSCD_LPRC_NS / `RST_CLK_PERIOD_NS)
`define RST_TOST_PERIODS    1024
`define RST_TLOCK_NS        1500000
`define RST_TFSCM_NS        900000
`define RST_POWERUP_TIMER_STEP_NS    2000000
`define RST_EXT_MIN_NS      200
`define RST_EXT_MIN_CYC     ((`RST_EXT_MIN_NS + `RST_CLK_PERIOD_NS - 1) / `RST_CLK_PERIOD_NS)

`define RST_REG_CAUSE       4'h0
`define RST_REG_OSCCTL      4'h4
`define RST_CAUSE_RESET     16'h0003
`define RST_CAUSE_WMASK     16'hC3FF
`define RST_CAUSE_BOR_KEEP  16'h01A1
`define RST_BIT_POR         0
`define RST_BIT_BOR         1
`define RST_BIT_WDTSOFT     5
`define RST_BIT_SWR         6
`define RST_BIT_EXT_RESET_FLAG        7
`define RST_OSCCTL_CUR_LSB  12

`define RST_OSC_FRC         3'h0
`define RST_OSC_FRCPLL      3'h1
`define RST_OSC_PRI         3'h2
`define RST_OSC_PRIPLL      3'h3
`define RST_OSC_SOSC        3'h4
`define RST_OSC_LPRC        3'h5
`define RST_VECTOR          24'h000000

`endif

/* File: rtl/rst_seq_pkg.sv */
package rst_seq_pkg;

   typedef enum logic [3:0] {
      sPorHold, sBorHold, sPwrt, sOscd, sOst, sLock, sExtHold, sSwRst, sRun
   } rst_state_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;

   typedef struct packed {
      logic [2:0] initialOscSelect;
      logic [2:0] powerupDelaySelect;
      logic       wdtFuseEnable;
      logic       fscmEnable;
      logic       primaryIsExternal;
   } fuse_cfg_s;

endpackage : rst_seq_pkg

/* File: rtl/system_reset_sequencer.sv */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "rst_seq_cfg.svh"
// What this block does
// [R01] Brown-out sets cause bit 1, sticky.
// [R02] Power-on sets cause bit 0.
// [R03] Software sets/clears flags, never causes reset.
// [R04] Watchdog fuse at 1 forces watchdog on.
// [R05] Cold reset loads initial oscillator select.
// [R06] Warm reset keeps current oscillator source.
// [R07] Power-on hold plus 30 us extension.
// [R08] Brown-out hold plus 100 us extension.
// [R09] Power-up timer holds reset, then releases.
// [R10] Three-bit select, eight delays 0-128 ms.
// [R11] Clock-ready delay depends on oscillator mode.
// [R12] Start-up timer counts 1024 oscillator periods.
// [R13] PLL modes add 1.5 ms lock wait.
// [R14] Start-up delay 1.1 us or 70 us.
// [R15] Fetch begins at address zero.
// [R16] Clock-fail monitor starts 900 us after ready.
// [R17] Brown-out plus power-up delay restarts on rise.
// [R18] Filtered reset pin low sets external flag.
// [R19] Supervisor may drive the reset pin.
// [R20] Reset instruction releases after one cycle.
// [R21] All delays but the start-up timer counted on internal reference clock.
module system_reset_sequencer #(
   parameter int unsigned PwrtStepCycles = `RST_POWERUP_TIMER_STEP_NS / `RST_CLK_PERIOD_NS,
   parameter int unsigned LockCycles     = `RST_TLOCK_NS / `RST_CLK_PERIOD_NS,
   parameter int unsigned FscmCycles     = `RST_TFSCM_NS / `RST_CLK_PERIOD_NS
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire rst_seq_pkg::reg_req_s  regReq,
   input  wire rst_seq_pkg::fuse_cfg_s cfg,
   input  wire logic                   supplyAbovePor,
   input  wire logic                   supplyAboveBor,
   input  wire logic                   ext_reset_pin_n,
   input  wire logic                   oscClkIn,
   input  wire logic                   swResetReq,
   output logic [15:0]                 rdata_q,
   output logic                        systemReset_q,
   output logic                        fetchStart_q,
   output logic [23:0]                 resetVector_q,
   output logic [2:0]                  currentOsc_q,
   output logic                        wdtEnable_q,
   output logic                        clockFailMonitorActive_q
);

   localparam logic [21:0] TporCyc  = 22'(`RST_TPOR_CYC);
   localparam logic [21:0] TborCyc  = 22'(`RST_TBOR_CYC);
   localparam logic [21:0] FrcCyc   = 22'(`RST_TOSCD_FRC_CYC);
   localparam logic [21:0] LprcCyc  = 22'(`RST_TOSCD_LPRC_CYC);
   localparam logic [21:0] OstCyc   = 22'(`RST_TOST_PERIODS);
   localparam logic [21:0] LockCyc  = 22'(LockCycles);
   localparam logic [21:0] StepCyc  = 22'(PwrtStepCycles);
   localparam logic [15:0] FscmCyc  = 16'(FscmCycles);
   localparam logic [3:0]  ExtMin   = 4'(`RST_EXT_MIN_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic       oscPrev_q;
   wire  [3:0] asyncIn = {oscClkIn, ext_reset_pin_n, supplyAboveBor, supplyAbovePor};

   // The reset pin may be driven straight by a supervisor, so it is treated as fully asynchronous.
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q   <= 4'h4;
         sync2_q   <= 4'h4;
         oscPrev_q <= 1'b0;
      end else begin
         sync1_q   <= asyncIn; // [R19]
         sync2_q   <= sync1_q;
         oscPrev_q <= sync2_q[3];
      end
   end

   wire porOk   = sync2_q[0];
   wire borOk   = sync2_q[1];
   wire extLow  = !sync2_q[2];
   wire oscEdge = sync2_q[3] && !oscPrev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin glitch filter.

   logic [3:0] lowCnt_q;
   wire        extAccept = extLow && (lowCnt_q == ExtMin - 4'h1); // [R18]

   always_ff @(posedge clk) begin
      if (rst || !extLow) begin
         lowCnt_q <= 4'h0;
      end else if (lowCnt_q != ExtMin) begin
         lowCnt_q <= lowCnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator mode decode and phase targets.

   rst_seq_pkg::rst_state_e state_q;
   rst_seq_pkg::rst_state_e stateD;
   logic [21:0]             cnt_q;

   wire [2:0] oscSel   = cfg.initialOscSelect;
   wire [2:0] pwrtSel  = cfg.powerupDelaySelect;
   wire       isPri    = (oscSel == `RST_OSC_PRI) || (oscSel == `RST_OSC_PRIPLL);
   wire       usesPll  = (oscSel == `RST_OSC_FRCPLL) || (oscSel == `RST_OSC_PRIPLL); // [R13]
   wire       needOscd = !(isPri && cfg.primaryIsExternal); // [R11]
   wire       needOst  = (isPri && !cfg.primaryIsExternal) || (oscSel == `RST_OSC_SOSC); // [R11]
   wire [21:0] oscdCyc = (oscSel == `RST_OSC_LPRC) ? LprcCyc : FrcCyc; // [R14]
   // Setting zero means no delay, the others double from 2 ms up to 128 ms.
   wire [21:0] pwrtCyc = (pwrtSel == 3'h0) ? 22'h0 : (StepCyc << (pwrtSel - 3'h1)); // [R10]

   rst_seq_pkg::rst_state_e afterOst;
   rst_seq_pkg::rst_state_e afterOscd;
   rst_seq_pkg::rst_state_e afterPwrt;
   assign afterOst  = usesPll ? rst_seq_pkg::sLock : rst_seq_pkg::sRun; // [R13]
   assign afterOscd = needOst ? rst_seq_pkg::sOst : afterOst; // [R12]
   assign afterPwrt = needOscd ? rst_seq_pkg::sOscd : afterOscd; // [R11]

   wire [21:0] target =
      (state_q == rst_seq_pkg::sPorHold) ? TporCyc :
      (state_q == rst_seq_pkg::sBorHold) ? TborCyc :
      (state_q == rst_seq_pkg::sPwrt)    ? pwrtCyc :
      (state_q == rst_seq_pkg::sOscd)    ? oscdCyc :
      (state_q == rst_seq_pkg::sOst)     ? OstCyc  : LockCyc;

   // The start-up timer advances on oscillator edges, every other phase on the reference clock.
   wire        cntInc    = (state_q == rst_seq_pkg::sOst) ? oscEdge : 1'b1; // [R12]
   wire [21:0] cntSum    = cnt_q + {21'h0, cntInc};
   wire        phaseDone = cntSum >= target;

   wire coldState = (state_q == rst_seq_pkg::sPorHold) || (state_q == rst_seq_pkg::sBorHold)
                    || (state_q == rst_seq_pkg::sPwrt);
   wire porEvt    = !porOk && (state_q != rst_seq_pkg::sPorHold);
   wire borEvt    = porOk && !borOk && (state_q != rst_seq_pkg::sPorHold)
                    && (state_q != rst_seq_pkg::sBorHold);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_comb begin
      stateD = state_q;
      if (!porOk) begin
         stateD = rst_seq_pkg::sPorHold; // [R07]
      end else if (!borOk && (state_q != rst_seq_pkg::sPorHold)) begin
         stateD = rst_seq_pkg::sBorHold; // [R08] [R17]
      end else if (extAccept && !coldState) begin
         stateD = rst_seq_pkg::sExtHold; // [R18]
      end else begin
         unique case (state_q)
            rst_seq_pkg::sPorHold: if (phaseDone) stateD = rst_seq_pkg::sBorHold; // [R07]
            rst_seq_pkg::sBorHold: if (phaseDone) stateD = rst_seq_pkg::sPwrt; // [R08]
            rst_seq_pkg::sPwrt:    if (phaseDone) stateD = afterPwrt; // [R09]
            rst_seq_pkg::sOscd:    if (phaseDone) stateD = afterOscd; // [R14]
            rst_seq_pkg::sOst:     if (phaseDone) stateD = afterOst; // [R12]
            rst_seq_pkg::sLock:    if (phaseDone) stateD = rst_seq_pkg::sRun; // [R13]
            rst_seq_pkg::sExtHold: if (!extLow) stateD = rst_seq_pkg::sRun;
            rst_seq_pkg::sSwRst:   stateD = rst_seq_pkg::sRun; // [R20]
            rst_seq_pkg::sRun:     if (swResetReq) stateD = rst_seq_pkg::sSwRst; // [R20]
            default:               stateD = rst_seq_pkg::sPorHold;
         endcase
      end
   end

   // A supply dip restarts the extension from zero rather than resuming it.
   wire cntClr = (stateD != state_q) || (state_q == rst_seq_pkg::sPorHold && !porOk)
                 || (state_q == rst_seq_pkg::sBorHold && !borOk); // [R17]

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= rst_seq_pkg::sPorHold;
         cnt_q   <= 22'h0;
      end else begin
         state_q <= stateD;
         cnt_q   <= cntClr ? 22'h0 : cntSum; // [R21]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock-fail monitor start delay.

   logic [15:0] fscmCnt_q;
   wire         fscmCount = (state_q == rst_seq_pkg::sRun) && cfg.fscmEnable && !clockFailMonitorActive_q;

   always_ff @(posedge clk) begin
      if (rst || coldState) begin
         fscmCnt_q                <= 16'h0;
         clockFailMonitorActive_q <= 1'b0;
      end else if (fscmCount) begin
         fscmCnt_q                <= fscmCnt_q + 16'h1; // [R21]
         clockFailMonitorActive_q <= (fscmCnt_q == FscmCyc - 16'h1); // [R16]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset cause register and outputs.

   logic [15:0] cause_q;
   wire         causeHit = regReq.addr == `RST_REG_CAUSE;
   wire         swEntry  = (stateD == rst_seq_pkg::sSwRst) && (state_q != rst_seq_pkg::sSwRst);
   // A write only stores bits; no path leads from here to the sequencer.
   wire [15:0]  causeWr  = (regReq.wr && causeHit) ? (regReq.wdata & `RST_CAUSE_WMASK) : cause_q; // [R03]
   wire [15:0]  causeClr = porEvt ? `RST_CAUSE_RESET : // [R02]
                           borEvt ? ((causeWr & `RST_CAUSE_BOR_KEEP) | 16'h0002) : causeWr; // [R01]
   // Hardware sets are ORed in last so an event beats a software clear in the same cycle.
   wire [15:0]  causeD   = causeClr | {8'h0, extAccept, swEntry, 6'h0}; // [R18] [R20]
   wire [15:0]  rdataD   = !regReq.rd ? 16'h0 :
                           causeHit ? cause_q :
                           (regReq.addr == `RST_REG_OSCCTL) ? {1'b0, currentOsc_q, 12'h0} : 16'h0;
   wire [2:0]   curOscD  = coldState ? oscSel : currentOsc_q; // [R05] [R06]

   always_ff @(posedge clk) begin
      if (rst) begin
         cause_q       <= `RST_CAUSE_RESET;
         rdata_q       <= 16'h0;
         systemReset_q <= 1'b1;
         fetchStart_q  <= 1'b0;
         resetVector_q <= `RST_VECTOR;
         currentOsc_q  <= `RST_OSC_FRC;
         wdtEnable_q   <= 1'b1;
      end else begin
         cause_q       <= causeD;
         rdata_q       <= rdataD;
         systemReset_q <= stateD != rst_seq_pkg::sRun; // [R09]
         fetchStart_q  <= (stateD == rst_seq_pkg::sRun) && (state_q != rst_seq_pkg::sRun); // [R15]
         resetVector_q <= `RST_VECTOR; // [R15]
         currentOsc_q  <= curOscD;
         wdtEnable_q   <= cfg.wdtFuseEnable | cause_q[`RST_BIT_WDTSOFT]; // [R04]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_por_flag_set: assert property (@(posedge clk) disable iff (rst) // [R02]
      porEvt |=> cause_q[`RST_BIT_POR] && cause_q[`RST_BIT_BOR])
      else $error("power-on flag not set");

   a_bor_flag_set: assert property (@(posedge clk) disable iff (rst) // [R01]
      borEvt |=> cause_q[`RST_BIT_BOR] && cause_q[`RST_BIT_SWR] == 1'b0)
      else $error("brown-out flag not set");

   a_bor_flag_sticky: assert property (@(posedge clk) disable iff (rst) // [R01]
      cause_q[`RST_BIT_BOR] && !(regReq.wr && causeHit) |=> cause_q[`RST_BIT_BOR])
      else $error("brown-out flag lost without a write");

   a_soft_write_safe: assert property (@(posedge clk) disable iff (rst) // [R03]
      state_q == rst_seq_pkg::sRun && regReq.wr && !swResetReq && !extAccept && porOk && borOk
      |=> !systemReset_q && state_q == rst_seq_pkg::sRun)
      else $error("register write disturbed the reset state");

   a_wdt_fuse_on: assert property (@(posedge clk) disable iff (rst) // [R04]
      cfg.wdtFuseEnable |=> wdtEnable_q)
      else $error("watchdog off while fuse forces it on");

   a_cold_osc_load: assert property (@(posedge clk) disable iff (rst) // [R05]
      state_q == rst_seq_pkg::sPwrt |-> currentOsc_q == $past(cfg.initialOscSelect))
      else $error("cold reset did not load initial oscillator");

   a_warm_osc_keep: assert property (@(posedge clk) disable iff (rst) // [R06]
      (state_q == rst_seq_pkg::sExtHold || state_q == rst_seq_pkg::sSwRst) |=> $stable(currentOsc_q))
      else $error("warm reset changed the oscillator");

   a_por_extension: assert property (@(posedge clk) disable iff (rst) // [R07]
      state_q == rst_seq_pkg::sPorHold && stateD == rst_seq_pkg::sBorHold |-> cnt_q == TporCyc - 22'h1)
      else $error("power-on extension length wrong");

   a_bor_extension: assert property (@(posedge clk) disable iff (rst) // [R08]
      state_q == rst_seq_pkg::sBorHold && stateD == rst_seq_pkg::sPwrt |-> cnt_q == TborCyc - 22'h1)
      else $error("brown-out extension length wrong");

   a_reset_held: assert property (@(posedge clk) disable iff (rst) // [R09]
      state_q != rst_seq_pkg::sRun |-> systemReset_q)
      else $error("system reset released early");

   a_ost_periods: assert property (@(posedge clk) disable iff (rst) // [R12]
      state_q == rst_seq_pkg::sOst && stateD != rst_seq_pkg::sOst && porOk && borOk && !extAccept
      |-> oscEdge && cnt_q == OstCyc - 22'h1)
      else $error("start-up timer period count wrong");

   a_fetch_vector: assert property (@(posedge clk) disable iff (rst) // [R15]
      fetchStart_q |-> !systemReset_q && $past(systemReset_q) && resetVector_q == `RST_VECTOR)
      else $error("fetch start without reset release");

   a_clock_fail_monitor_start: assert property (@(posedge clk) disable iff (rst) // [R16]
      $rose(clockFailMonitorActive_q) |-> $past(fscmCnt_q) == FscmCyc - 16'h1)
      else $error("clock-fail monitor started at wrong time");

   a_ext_filter: assert property (@(posedge clk) disable iff (rst) // [R18]
      extAccept |-> $past(extLow) && $past(extLow, 2) && $past(extLow, 3))
      else $error("short reset pin pulse accepted");

   a_sw_release: assert property (@(posedge clk) disable iff (rst) // [R20]
      state_q == rst_seq_pkg::sSwRst && porOk && borOk && !extAccept
      |=> state_q == rst_seq_pkg::sRun && fetchStart_q)
      else $error("software reset not released after one cycle");

   ////////////////////////////////////////////////////////////////////////////
   // Phase and flag checks that the bench reaches only through rarer paths.

   a_por_hold: assert property (@(posedge clk) disable iff (rst) // [R07]
      !porOk |=> state_q == rst_seq_pkg::sPorHold && systemReset_q)
      else $error("supply below power-on threshold did not hold reset");

   a_bor_enter: assert property (@(posedge clk) disable iff (rst) // [R08]
      porOk && !borOk && state_q != rst_seq_pkg::sPorHold |=> state_q == rst_seq_pkg::sBorHold)
      else $error("supply below brown-out threshold did not hold reset");

   a_bor_restart: assert property (@(posedge clk) disable iff (rst) // [R17]
      state_q == rst_seq_pkg::sBorHold && !borOk |=> cnt_q == 22'h0)
      else $error("brown-out extension not restarted");

   a_powerup_timer_zero: assert property (@(posedge clk) disable iff (rst) // [R10]
      state_q == rst_seq_pkg::sPwrt && pwrtSel == 3'h0 |=> state_q != rst_seq_pkg::sPwrt)
      else $error("zero power-up setting still waited");

   a_powerup_timer_first: assert property (@(posedge clk) disable iff (rst) // [R10]
      state_q == rst_seq_pkg::sPwrt && stateD != rst_seq_pkg::sPwrt && pwrtSel == 3'h1 && porOk && borOk
      |-> cnt_q == StepCyc - 22'h1)
      else $error("shortest power-up delay length wrong");

   a_oscd_length: assert property (@(posedge clk) disable iff (rst) // [R14]
      state_q == rst_seq_pkg::sOscd && stateD == afterOscd |-> cnt_q == oscdCyc - 22'h1)
      else $error("oscillator start-up delay length wrong");

   a_ost_hold_count: assert property (@(posedge clk) disable iff (rst) // [R12]
      state_q == rst_seq_pkg::sOst && !oscEdge && stateD == rst_seq_pkg::sOst |=> cnt_q == $past(cnt_q))
      else $error("start-up timer moved without an oscillator edge");

   a_lock_length: assert property (@(posedge clk) disable iff (rst) // [R13]
      state_q == rst_seq_pkg::sLock && stateD == rst_seq_pkg::sRun |-> cnt_q == LockCyc - 22'h1)
      else $error("lock wait length wrong");

   a_run_released: assert property (@(posedge clk) disable iff (rst) // [R09]
      state_q == rst_seq_pkg::sRun && stateD == rst_seq_pkg::sRun |=> !systemReset_q)
      else $error("system reset asserted while running");

   a_pin_cold_ignored: assert property (@(posedge clk) disable iff (rst) // [R18]
      coldState |=> state_q != rst_seq_pkg::sExtHold)
      else $error("reset pin acted during a cold reset");

   a_ext_flag_set: assert property (@(posedge clk) disable iff (rst) // [R18]
      extAccept && !coldState && porOk && borOk |=> cause_q[`RST_BIT_EXT_RESET_FLAG] && state_q == rst_seq_pkg::sExtHold)
      else $error("accepted pin reset did not set its flag");

   a_ext_release: assert property (@(posedge clk) disable iff (rst) // [R18]
      state_q == rst_seq_pkg::sExtHold && !extLow && porOk && borOk |=> state_q == rst_seq_pkg::sRun && fetchStart_q)
      else $error("pin reset not released when pin went high");

   a_sw_flag_set: assert property (@(posedge clk) disable iff (rst) // [R20]
      swEntry |=> cause_q[`RST_BIT_SWR] && systemReset_q)
      else $error("reset instruction did not set its flag");

   a_monitor_cold_off: assert property (@(posedge clk) disable iff (rst) // [R16]
      coldState |=> !clockFailMonitorActive_q)
      else $error("clock-fail monitor active during cold reset");

   a_monitor_disabled: assert property (@(posedge clk) disable iff (rst) // [R16]
      !cfg.fscmEnable && !clockFailMonitorActive_q |=> !clockFailMonitorActive_q)
      else $error("clock-fail monitor started while disabled");

   a_wdt_soft_follow: assert property (@(posedge clk) disable iff (rst) // [R04]
      !cfg.wdtFuseEnable |=> wdtEnable_q == $past(cause_q[`RST_BIT_WDTSOFT]))
      else $error("watchdog enable does not follow software bit");

   a_rdata_idle: assert property (@(posedge clk) disable iff (rst) // [R03]
      !regReq.rd |=> rdata_q == 16'h0)
      else $error("read data present without a read");

endmodule : system_reset_sequencer

/* File: tb/ext_supervisor.sv */
`timescale 1ns/10ps
// Stands in for an external supervisor wired straight to the reset pin.
// Between requests the pin sits at the supply level, as a tied pin would.
module ext_supervisor (
   clk,
   go,
   pulseLen,
   resetPinN
);
   input  wire logic       clk;
   input  wire logic       go;
   input  wire logic [7:0] pulseLen;
   output wire logic       resetPinN;

   logic [7:0] lowCnt_q = 8'h00;

   always_ff @(posedge clk) begin
      if (go) begin
         lowCnt_q <= pulseLen;
      end else if (lowCnt_q != 8'h00) begin
         lowCnt_q <= lowCnt_q - 8'h01;
      end
   end

   assign resetPinN = (lowCnt_q == 8'h00);
endmodule : ext_supervisor

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
   localparam int PorCyc = 600 + 2000 + 4 + 22 + 5;
   localparam int BorCyc = 2000 + 4 + 22 + 5;
   // Crystal start-up: 1024 oscillator edges at four reference cycles each, less the first edge's phase.
   localparam int XtalCyc = 600 + 2000 + 1 + 22 + 4092;
   logic                   clk      = 1'b0;
   logic                   rst      = 1'b1;
   rst_seq_pkg::reg_req_s  regReq   = '0;
   rst_seq_pkg::fuse_cfg_s cfg      = '{3'h1, 3'h1, 1'b1, 1'b1, 1'b0};
   logic                   porOk    = 1'b0;
   logic                   borOk    = 1'b0;
   logic                   oscClk   = 1'b0;
   logic                   swReq    = 1'b0;
   logic                   pulseGo  = 1'b0;
   logic [7:0]             pulseLen = 8'h00;
   wire logic              pinN;
   logic [15:0]            rdata;
   logic [15:0]            d;
   logic                   system_reset;
   logic                   fetch;
   logic                   wdtEn;
   logic                   fscmOn;
   logic [23:0]            vec;
   logic [2:0]             curOsc;
   int                     failures = 0;
   int                     cmpCount = 0;
   int                     n;

   always #25 clk = ~clk;
   always #100 oscClk = ~oscClk;

   ext_supervisor u_sup (.clk(clk), .go(pulseGo), .pulseLen(pulseLen), .resetPinN(pinN));

   system_reset_sequencer #(.PwrtStepCycles(4), .LockCycles(5), .FscmCycles(6)) u_dut (
      .clk(clk), .rst(rst), .regReq(regReq), .cfg(cfg), .supplyAbovePor(porOk), .supplyAboveBor(borOk),
      .ext_reset_pin_n(pinN), .oscClkIn(oscClk), .swResetReq(swReq), .rdata_q(rdata), .systemReset_q(system_reset),
      .fetchStart_q(fetch), .resetVector_q(vec), .currentOsc_q(curOsc), .wdtEnable_q(wdtEn),
      .clockFailMonitorActive_q(fscmOn));

   ////////////////////////////////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (failures == 0 && cmpCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
      cmpCount++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic regWrite(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      regReq <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      regReq.wr <= 1'b0;
   endtask : regWrite

   // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
   task automatic regRead(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      regReq <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk);
      regReq.rd <= 1'b0;
      #1;
      v = rdata;
   endtask : regRead

   task automatic waitFetch(output int cnt);
      cnt = 0;
      while (fetch !== 1'b1) begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > 10000) begin
            failures++;
            $display("ERROR fetchStart expected 1 seen timeout");
            test_done();
         end
      end
   endtask : waitFetch

   ////////////////////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst   <= 1'b0;
      @(posedge clk);
      porOk <= 1'b1;
      borOk <= 1'b1;
      waitFetch(n);
      cmp("cold release in window", 1'b1, n >= PorCyc && n <= PorCyc + 10);
      cmp("systemReset at run", 1'b0, system_reset);
      cmp("reset vector", 24'h000000, vec);
      cmp("osc after cold", 3'h1, curOsc);
      cmp("monitor at run", 1'b0, fscmOn);
      tick(8);
      cmp("monitor later", 1'b1, fscmOn);
      regRead(4'h0, d);
      cmp("cause after power-on", 16'h0003, d);
      regWrite(4'h0, 16'hFFFF);
      regRead(4'h0, d);
      cmp("cause all set", 16'hC3FF, d);
      cmp("no reset from set", 1'b0, system_reset);
      regRead(4'h4, d);
      cmp("osc control", 16'h1000, d);
      regRead(4'h8, d);
      cmp("unmapped read", 16'h0000, d);
      regWrite(4'h0, 16'h0000);
      tick(2);
      cmp("wdt forced by fuse", 1'b1, wdtEn);
      @(posedge clk);
      cfg.wdtFuseEnable <= 1'b0;
      regWrite(4'h0, 16'h0020);
      tick(2);
      cmp("wdt soft on", 1'b1, wdtEn);
      regWrite(4'h0, 16'h0000);
      tick(2);
      cmp("wdt soft off", 1'b0, wdtEn);
      @(posedge clk);
      swReq <= 1'b1;
      @(posedge clk);
      swReq <= 1'b0;
      #1;
      cmp("sw reset asserted", 1'b1, system_reset);
      tick(1);
      cmp("sw reset released", 1'b0, system_reset);
      cmp("sw reset fetch", 1'b1, fetch);
      regRead(4'h0, d);
      cmp("cause after sw reset", 16'h0040, d);
      cmp("osc kept on warm", 3'h1, curOsc);
      regWrite(4'h0, 16'h0000);
      @(posedge clk);
      pulseLen <= 8'h02;
      pulseGo  <= 1'b1;
      @(posedge clk);
      pulseGo  <= 1'b0;
      tick(12);
      cmp("short pin pulse", 1'b0, system_reset);
      regRead(4'h0, d);
      cmp("cause after glitch", 16'h0000, d);
      @(posedge clk);
      pulseLen <= 8'h0A;
      pulseGo  <= 1'b1;
      @(posedge clk);
      pulseGo  <= 1'b0;
      tick(10);
      cmp("pin reset held", 1'b1, system_reset);
      waitFetch(n);
      regRead(4'h0, d);
      cmp("cause after pin", 16'h0080, d);
      cmp("monitor kept on warm", 1'b1, fscmOn);
      regWrite(4'h0, 16'hFFFF);
      @(posedge clk);
      borOk <= 1'b0;
      tick(10);
      cmp("brown-out holds", 1'b1, system_reset);
      @(posedge clk);
      borOk <= 1'b1;
      tick(500);
      @(posedge clk);
      borOk <= 1'b0;
      tick(5);
      @(posedge clk);
      borOk <= 1'b1;
      waitFetch(n);
      cmp("brown-out release window", 1'b1, n >= BorCyc && n <= BorCyc + 10);
      regRead(4'h0, d);
      cmp("cause after brown-out", 16'h01A3, d);
      @(posedge clk);
      cfg   <= '{3'h2, 3'h0, 1'b0, 1'b1, 1'b0};
      porOk <= 1'b0;
      borOk <= 1'b0;
      tick(10);
      cmp("power-on holds", 1'b1, system_reset);
      cmp("monitor off after cold", 1'b0, fscmOn);
      @(posedge clk);
      porOk <= 1'b1;
      borOk <= 1'b1;
      waitFetch(n);
      cmp("crystal release window", 1'b1, n >= XtalCyc && n <= XtalCyc + 12);
      regRead(4'h0, d);
      cmp("cause after power-on dip", 16'h0003, d);
      tick(1);
      cmp("read data idle", 16'h0000, rdata);
      regRead(4'h4, d);
      cmp("osc after crystal cold", 16'h2000, d);
      cmp("wdt off without fuse", 1'b0, wdtEn);
      test_done();
   end
endmodule : tb
